// >>> actc_trim_config_regs.sv
// Behaviour
// - gain low byte sits in bits 15:8
// - gain word is unsigned, range 0 to just under 2
// - gain low at 0Dh, reset 0000h
// - channel 1 config at 0Eh, reset 0000h
// - bits 15:6 signed phase delay
// - bit 2 set disables channel DC block
// - bits 1:0 select input or test source
// - gain high gives bits 23:8, reset unity
//
// The APB slave port was chosen for this implementation.
module actc_trim_config_regs
  import actc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SAMPLE_W = ACTC_SAMPLE_W,
  parameter logic [SAMPLE_W-1:0] TEST_POS_LEVEL = 24'h400000,
  parameter logic [SAMPLE_W-1:0] TEST_NEG_LEVEL = 24'hc00000
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [ACTC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ACTC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel 0 sample path
  input wire logic signed [SAMPLE_W-1:0] ch0_sample_in,
  input wire logic ch0_sample_in_valid,
  output logic signed [SAMPLE_W-1:0] ch0_sample_out,
  output logic ch0_sample_out_valid,
  // Channel 1 sample path
  input wire logic signed [SAMPLE_W-1:0] ch1_sample_in,
  input wire logic ch1_sample_in_valid,
  output logic signed [SAMPLE_W-1:0] ch1_sample_out,
  output logic ch1_sample_out_valid,
  // Settings to the datapath
  output logic [ACTC_GAIN_W-1:0] ch0_gain_word,
  output logic signed [ACTC_PHASE_W-1:0] ch1_phase_delay,
  output logic ch1_dc_block_en,
  output logic [ACTC_MUX_W-1:0] ch1_input_select
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte lanes of the low half word gate the write mask
  function automatic logic [ACTC_REG_W-1:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Masked merge keeps reserved bits at zero whatever is written
  function automatic logic [ACTC_REG_W-1:0] merge_wr(
    input logic [ACTC_REG_W-1:0] old,
    input logic [ACTC_REG_W-1:0] wdat,
    input logic [ACTC_REG_W-1:0] wmask,
    input logic [3:0] strb
  );
    logic [ACTC_REG_W-1:0] m;
    m = wmask & lane_mask(strb);
    merge_wr = (old & ~m) | (wdat & m);
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [ACTC_IDX_W-1:0] idx;
  logic aligned;
  logic hit_gain_high;
  logic hit_gain_low;
  logic hit_ch1_channel_config;
  logic hit_global_dc;
  logic hit_status;
  logic addr_hit;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic [ACTC_REG_W-1:0] wdat16;

  assign idx = paddr[ACTC_IDX_LSB +: ACTC_IDX_W];
  assign aligned = (paddr[ACTC_IDX_LSB-1:0] == ACTC_ALIGN_OK);
  assign hit_gain_high = aligned & (idx == ACTC_IDX_GAIN_HIGH);
  assign hit_gain_low = aligned & (idx == ACTC_IDX_GAIN_LOW);
  assign hit_ch1_channel_config = aligned & (idx == ACTC_IDX_CH1_CHANNEL_CONFIG);
  assign hit_global_dc = aligned & (idx == ACTC_IDX_GLOBAL_DC);
  assign hit_status = aligned & (idx == ACTC_IDX_STATUS);
  assign addr_hit = hit_gain_high | hit_gain_low | hit_ch1_channel_config | hit_global_dc | hit_status;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en = access_ph & pwrite & addr_hit;
  assign wdat16 = pwdata[ACTC_REG_W-1:0];

  // Zero wait states; unmapped or unaligned words answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_hit;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [ACTC_REG_W-1:0] gain_high_r;
  logic [ACTC_REG_W-1:0] gain_low_r;
  logic [ACTC_REG_W-1:0] ch1_channel_config_r;
  logic [ACTC_REG_W-1:0] global_dc_r;
  logic sat_seen_r;
  logic [ACTC_REG_W-1:0] gain_high_nxt;
  logic [ACTC_REG_W-1:0] gain_low_nxt;
  logic [ACTC_REG_W-1:0] ch1_channel_config_nxt;
  logic [ACTC_REG_W-1:0] global_dc_nxt;
  logic sat_seen_nxt;
  logic sat_pulse;
  logic sat_clear;

  assign gain_high_nxt = (wr_en & hit_gain_high) ?
    merge_wr(gain_high_r, wdat16, ACTC_WMASK_GAIN_HIGH, pstrb) : gain_high_r;
  assign gain_low_nxt = (wr_en & hit_gain_low) ?
    merge_wr(gain_low_r, wdat16, ACTC_WMASK_GAIN_LOW, pstrb) : gain_low_r;
  assign ch1_channel_config_nxt = (wr_en & hit_ch1_channel_config) ?
    merge_wr(ch1_channel_config_r, wdat16, ACTC_WMASK_CH1_CHANNEL_CONFIG, pstrb) : ch1_channel_config_r;
  assign global_dc_nxt = (wr_en & hit_global_dc) ?
    merge_wr(global_dc_r, wdat16, ACTC_WMASK_GLOBAL_DC, pstrb) : global_dc_r;

  // Write one to clear; a saturation in the same cycle still wins
  assign sat_clear = wr_en & hit_status & pstrb[0] & pwdata[ACTC_ST_SAT_BIT];
  assign sat_seen_nxt = sat_pulse | (sat_seen_r & ~sat_clear);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_high_r <= ACTC_RST_GAIN_HIGH;
      gain_low_r <= ACTC_RST_GAIN_LOW;
      ch1_channel_config_r <= ACTC_RST_CH1_CHANNEL_CONFIG;
      global_dc_r <= ACTC_RST_GLOBAL_DC;
      sat_seen_r <= 1'b0;
    end
    else
    begin
      gain_high_r <= gain_high_nxt;
      gain_low_r <= gain_low_nxt;
      ch1_channel_config_r <= ch1_channel_config_nxt;
      global_dc_r <= global_dc_nxt;
      sat_seen_r <= sat_seen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [ACTC_GAIN_W-1:0] gain_word;
  logic global_dc_on;
  logic dc_block_active;
  actc_input_e sel_mode;

  // High word supplies 23:8, low register's upper byte supplies 7:0
  assign gain_word = {gain_high_r,
    gain_low_r[ACTC_GAIN_LOW_LSB +: ACTC_GAIN_LOW_W]};
  // Any nonzero global setting turns the filter on
  assign global_dc_on = |global_dc_r[ACTC_GDC_W-1:0];
  assign dc_block_active = global_dc_on & ~ch1_channel_config_r[ACTC_DCOFF_BIT];
  assign sel_mode = actc_input_e'(ch1_channel_config_r[ACTC_MUX_LSB +: ACTC_MUX_W]);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is captured in the setup phase so prdata is a flop
  logic [ACTC_REG_W-1:0] status_word;
  logic [ACTC_REG_W-1:0] rd_word;
  logic [ACTC_DATA_W-1:0] prdata_nxt;

  always_comb
  begin
    status_word = '0;
    status_word[ACTC_ST_DCACT_BIT] = dc_block_active;
    status_word[ACTC_ST_MUX_LSB +: ACTC_MUX_W] = sel_mode;
    status_word[ACTC_ST_SAT_BIT] = sat_seen_r;
  end

  assign rd_word = hit_gain_high ? gain_high_r :
                   hit_gain_low ? gain_low_r :
                   hit_ch1_channel_config ? ch1_channel_config_r :
                   hit_global_dc ? global_dc_r :
                   hit_status ? status_word : '0;
  assign prdata_nxt = (setup_ph & ~pwrite) ?
    {{(ACTC_DATA_W - ACTC_REG_W){1'b0}}, rd_word} : prdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else
    begin
      prdata <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Channel 0 gain trim
  // ----------------------------------------------------------------
  actc_gain_scaler #(
    .SAMPLE_W(SAMPLE_W),
    .GAIN_W(ACTC_GAIN_W),
    .FRAC(ACTC_GAIN_FRAC)
  ) u_gain (
    .pclk(pclk),
    .presetn(presetn),
    .sample_in(ch0_sample_in),
    .sample_in_valid(ch0_sample_in_valid),
    .gain(gain_word),
    .sample_out(ch0_sample_out),
    .sample_out_valid(ch0_sample_out_valid),
    .sat_pulse(sat_pulse)
  );

  // ----------------------------------------------------------------
  // Channel 1 input selection
  // ----------------------------------------------------------------
  // Test sources replace the sample but keep the input's cadence
  logic signed [SAMPLE_W-1:0] ch1_sel;

  always_comb
  begin
    unique case (sel_mode)
      ACTC_IN_NORMAL: ch1_sel = ch1_sample_in;
      ACTC_IN_SHORTED: ch1_sel = '0;
      ACTC_IN_TEST_POS: ch1_sel = TEST_POS_LEVEL;
      ACTC_IN_TEST_NEG: ch1_sel = TEST_NEG_LEVEL;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch1_sample_out <= '0;
      ch1_sample_out_valid <= 1'b0;
      ch0_gain_word <= {ACTC_RST_GAIN_HIGH,
        ACTC_RST_GAIN_LOW[ACTC_GAIN_LOW_LSB +: ACTC_GAIN_LOW_W]};
      ch1_phase_delay <= '0;
      ch1_dc_block_en <= 1'b0;
      ch1_input_select <= '0;
    end
    else
    begin
      ch1_sample_out_valid <= ch1_sample_in_valid;
      if (ch1_sample_in_valid)
      begin
        ch1_sample_out <= ch1_sel;
      end
      ch0_gain_word <= gain_word;
      ch1_phase_delay <= ch1_channel_config_r[ACTC_PHASE_LSB +: ACTC_PHASE_W];
      ch1_dc_block_en <= dc_block_active;
      ch1_input_select <= sel_mode;
    end
  end

endmodule

// >>> actc_pkg.sv
package actc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ACTC_DATA_W = 32;
  localparam int ACTC_REG_W = 16;
  localparam int ACTC_IDX_W = 6;
  localparam int ACTC_IDX_LSB = 2;
  localparam logic [1:0] ACTC_ALIGN_OK = 2'h0;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [ACTC_IDX_W-1:0] ACTC_IDX_GAIN_HIGH = 6'h0c;
  localparam logic [ACTC_IDX_W-1:0] ACTC_IDX_GAIN_LOW = 6'h0d;
  localparam logic [ACTC_IDX_W-1:0] ACTC_IDX_CH1_CHANNEL_CONFIG = 6'h0e;
  localparam logic [ACTC_IDX_W-1:0] ACTC_IDX_GLOBAL_DC = 6'h20;
  localparam logic [ACTC_IDX_W-1:0] ACTC_IDX_STATUS = 6'h21;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [ACTC_REG_W-1:0] ACTC_RST_GAIN_HIGH = 16'h8000;
  localparam logic [ACTC_REG_W-1:0] ACTC_RST_GAIN_LOW = 16'h0000;
  localparam logic [ACTC_REG_W-1:0] ACTC_RST_CH1_CHANNEL_CONFIG = 16'h0000;
  localparam logic [ACTC_REG_W-1:0] ACTC_RST_GLOBAL_DC = 16'h0000;
  localparam logic [ACTC_REG_W-1:0] ACTC_WMASK_GAIN_HIGH = 16'hffff;
  localparam logic [ACTC_REG_W-1:0] ACTC_WMASK_GAIN_LOW = 16'hff00;
  localparam logic [ACTC_REG_W-1:0] ACTC_WMASK_CH1_CHANNEL_CONFIG = 16'hffc7;
  localparam logic [ACTC_REG_W-1:0] ACTC_WMASK_GLOBAL_DC = 16'h000f;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ACTC_GAIN_W = 24;
  localparam int ACTC_GAIN_LOW_LSB = 8;
  localparam int ACTC_GAIN_LOW_W = 8;
  localparam int ACTC_GAIN_FRAC = 23;
  localparam int ACTC_PHASE_LSB = 6;
  localparam int ACTC_PHASE_W = 10;
  localparam int ACTC_DCOFF_BIT = 2;
  localparam int ACTC_MUX_LSB = 0;
  localparam int ACTC_MUX_W = 2;
  localparam int ACTC_GDC_W = 4;
  localparam int ACTC_ST_DCACT_BIT = 0;
  localparam int ACTC_ST_MUX_LSB = 1;
  localparam int ACTC_ST_SAT_BIT = 3;
  localparam int ACTC_SAMPLE_W = 24;

  typedef enum logic [ACTC_MUX_W-1:0] {
    ACTC_IN_NORMAL,
    ACTC_IN_SHORTED,
    ACTC_IN_TEST_POS,
    ACTC_IN_TEST_NEG
  } actc_input_e;

endpackage

// >>> actc_gain_scaler.sv
module actc_gain_scaler
  import actc_pkg::*;
#(
  parameter int SAMPLE_W = ACTC_SAMPLE_W,
  parameter int GAIN_W = ACTC_GAIN_W,
  parameter int FRAC = ACTC_GAIN_FRAC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample in
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  input wire logic sample_in_valid,
  // Unsigned gain word
  input wire logic [GAIN_W-1:0] gain,
  // Scaled sample out
  output logic signed [SAMPLE_W-1:0] sample_out,
  output logic sample_out_valid,
  output logic sat_pulse
);

  localparam int PW = SAMPLE_W + GAIN_W + 1;
  localparam logic signed [PW-1:0] MAXV = PW'((2 ** (SAMPLE_W - 1)) - 1);
  localparam logic signed [PW-1:0] MINV = -MAXV - PW'(1);

  // ----------------------------------------------------------------
  // Unsigned gain: a zero sign bit keeps the product from flipping
  // ----------------------------------------------------------------
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] shifted;
  logic over_hi;
  logic over_lo;
  logic signed [SAMPLE_W-1:0] clipped;

  assign prod = sample_in * $signed({1'b0, gain});
  assign shifted = prod >>> FRAC;
  assign over_hi = shifted > MAXV;
  assign over_lo = shifted < MINV;
  assign clipped = over_hi ? MAXV[SAMPLE_W-1:0] :
                   over_lo ? MINV[SAMPLE_W-1:0] : shifted[SAMPLE_W-1:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_out <= '0;
      sample_out_valid <= 1'b0;
      sat_pulse <= 1'b0;
    end
    else
    begin
      sample_out_valid <= sample_in_valid;
      sat_pulse <= sample_in_valid & (over_hi | over_lo);
      if (sample_in_valid)
      begin
        sample_out <= clipped;
      end
    end
  end

endmodule

// >>> actc_trim_config_regs_properties.sv
module actc_regs_chk
  import actc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SAMPLE_W = ACTC_SAMPLE_W
)
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [ACTC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [ACTC_DATA_W-1:0] prdata,
  // Settings and channel 1 output
  input wire logic [ACTC_GAIN_W-1:0] ch0_gain_word,
  input wire logic signed [ACTC_PHASE_W-1:0] ch1_phase_delay,
  input wire logic ch1_dc_block_en,
  input wire logic [ACTC_MUX_W-1:0] ch1_input_select,
  input wire logic signed [SAMPLE_W-1:0] ch1_sample_out,
  input wire logic ch1_sample_out_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire acc = psel && penable;
  wire wr_hi = acc && pwrite && paddr == 8'h30;
  wire wr_lo = acc && pwrite && paddr == 8'h34;
  wire wr_cfg = acc && pwrite && paddr == 8'h38;
  wire [7:0] wd_hi = pwdata[15:8];
  wire [15:0] wd16 = pwdata[15:0];
  wire [9:0] wd_ph = pwdata[15:6];
  wire [1:0] wd_mux = pwdata[1:0];
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  rst_values_a: assert property ($rose(presetn) |->
    ch0_gain_word == 24'h800000
    && ch1_phase_delay == 10'h000 && ch1_input_select == 2'h0 && !ch1_dc_block_en)
    else $error("settings not at reset values");
  gain_low_a: assert property (wr_lo && pstrb[1] |-> ##2
    ch0_gain_word[7:0] == $past(wd_hi, 2)) else $error("gain low byte not applied");
  gain_high_a: assert property (wr_hi && pstrb[1:0] == 2'h3 |-> ##2
    ch0_gain_word[23:8] == $past(wd16, 2)) else $error("gain high word not applied");
  phase_set_a: assert property (wr_cfg && pstrb[1:0] == 2'h3 |-> ##2
    ch1_phase_delay == $past(wd_ph, 2)) else $error("phase delay not applied");
  mux_set_a: assert property (wr_cfg && pstrb[0] |-> ##2
    ch1_input_select == $past(wd_mux, 2)) else $error("input select not applied");
  dc_off_a: assert property (wr_cfg && pstrb[0] && pwdata[2] |-> ##2 !ch1_dc_block_en)
    else $error("channel dc block not disabled");
  low_rsvd_a: assert property (acc && !pwrite && paddr == 8'h34 |->
    prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000) else $error("reserved gain bits set");
  cfg_rsvd_a: assert property (acc && !pwrite && paddr == 8'h38 |->
    prdata[5:3] == 3'h0 && prdata[15:6] == ch1_phase_delay) else $error("config readback wrong");
  short_zero_a: assert property (ch1_sample_out_valid
    && ch1_input_select == ACTC_IN_SHORTED
    && $past(ch1_input_select, 2) == ACTC_IN_SHORTED |-> ch1_sample_out == '0)
    else $error("shorted input not zero");
  cov_cfg_wr: cover property (wr_cfg);
  cov_lo_rd: cover property (acc && !pwrite && paddr == 8'h34);
  cov_short: cover property (ch1_sample_out_valid && ch1_input_select == ACTC_IN_SHORTED);
endmodule

bind actc_trim_config_regs actc_regs_chk #(.ADDR_W(ADDR_W), .SAMPLE_W(SAMPLE_W)) u_actc_regs_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .ch0_gain_word,
  .ch1_phase_delay, .ch1_dc_block_en, .ch1_input_select, .ch1_sample_out, .ch1_sample_out_valid);

// >>> adc_channel_trim_config_regs_tb.sv
module adc_channel_trim_config_regs_tb
  import actc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] POS_LVL = 24'h400000;
  localparam logic [23:0] NEG_LVL = 24'hc00000;
  localparam logic [7:0] ADDRS [4] = '{8'h30, 8'h34, 8'h38, 8'h80};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [31:0] seed = 32'h0000002c;
  logic sat_m = 1'b0;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, err, ch0_sample_in_valid = 1'b0, ch1_sample_in_valid = 1'b0;
  logic signed [23:0] ch0_sample_in = 24'h0, ch1_sample_in = 24'h0, ch0_sample_out, ch1_sample_out;
  logic ch0_sample_out_valid, ch1_sample_out_valid, ch1_dc_block_en;
  logic [23:0] ch0_gain_word;
  logic signed [9:0] ch1_phase_delay;
  logic [1:0] ch1_input_select;
  logic [15:0] mdl [0:63];
  int miscompares = 0, n_checks = 0, cyc = 0;
  actc_trim_config_regs #(.TEST_POS_LEVEL(POS_LVL), .TEST_NEG_LEVEL(NEG_LVL))
    u_actc_trim_config_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .ch0_sample_in, .ch0_sample_in_valid, .ch0_sample_out, .ch0_sample_out_valid, .ch1_sample_in,
    .ch1_sample_in_valid, .ch1_sample_out, .ch1_sample_out_valid, .ch0_gain_word,
    .ch1_phase_delay, .ch1_dc_block_en, .ch1_input_select);
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] wmask(input logic [7:0] a);
    case (a)
      8'h30: return 16'hffff;
      8'h34: return 16'hff00;
      8'h38: return 16'hffc7;
      8'h80: return 16'h000f;
      default: return 16'h0000;
    endcase
  endfunction
  // Leaves psel up so a following call makes a back-to-back transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = wmask(a) & {{8{s[1]}}, {8{s[0]}}};
    apb(1'b1, a, d, s);
    chk(err, wmask(a) == 0);
    mdl[a[7:2]] = (mdl[a[7:2]] & ~m) | (d & m);
  endtask
  task automatic rdchk(input logic [7:0] a);
    apb(1'b0, a, 16'h0, 4'h0);
    chk(rd, wmask(a) == 0 ? 32'h0 : {16'h0, mdl[a[7:2]]});
    chk(err, wmask(a) == 0);
  endtask
  // Status word: sticky saturation, input select, dc block active; then clear
  task automatic stchk();
    apb(1'b0, 8'h84, 16'h0, 4'h0);
    chk(rd, {28'h0, sat_m, mdl[14][1:0], mdl[32][3:0] != 0 && !mdl[14][2]});
    chk(err, 1'b0);
    apb(1'b1, 8'h84, 16'h0008, 4'h1);
    sat_m = 1'b0;
    chk(err, 1'b0);
  endtask
  task automatic setchk();
    chk(ch0_gain_word, {mdl[12], mdl[13][15:8]});
    chk({22'h0, ch1_phase_delay}, mdl[14][15:6]);
    chk(ch1_dc_block_en, mdl[32][3:0] != 0 && !mdl[14][2]);
    chk(ch1_input_select, mdl[14][1:0]);
  endtask
  task automatic smp(input logic [23:0] a, input logic [23:0] b);
    longint p;
    logic [23:0] e1;
    p = (longint'(signed'(a)) * longint'({mdl[12], mdl[13][15:8]})) >>> 23;
    if (p > 64'sh7fffff || p < -64'sh800000)
      sat_m = 1'b1;
    if (p > 64'sh7fffff)
      p = 64'sh7fffff;
    else if (p < -64'sh800000)
      p = -64'sh800000;
    case (mdl[14][1:0])
      2'h0: e1 = b;
      2'h1: e1 = 24'h0;
      2'h2: e1 = POS_LVL;
      default: e1 = NEG_LVL;
    endcase
    ch0_sample_in <= a;
    ch1_sample_in <= b;
    ch0_sample_in_valid <= 1'b1;
    ch1_sample_in_valid <= 1'b1;
    @(posedge pclk);
    ch0_sample_in_valid <= 1'b0;
    ch1_sample_in_valid <= 1'b0;
    #1;
    chk(ch0_sample_out_valid, 1'b1);
    chk({8'h0, ch0_sample_out}, p[23:0]);
    chk(ch1_sample_out_valid, 1'b1);
    chk({8'h0, ch1_sample_out}, e1);
    @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (mdl[i]) mdl[i] = 16'h0;
    mdl[12] = 16'h8000;
    sat_m = 1'b0;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rdchk(ADDRS[i]);
    stchk();
    idle();
    setchk();
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h80, {12'h0, i[3:0]}, 4'h1);
      wr(8'h38, {i[9:0] ^ 10'h2a5, 3'h7, i[0], i[1:0]}, 4'hf);
      rdchk(8'h38);
      idle();
      setchk();
      r = xs();
      smp(r[23:0], r[31:8]);
    end
    // Random strobes exercise partial-lane merges
    for (int i = 0; i < 40; i++)
    begin
      r = xs();
      wr(ADDRS[r[1:0]], r[31:16], r[5:2]);
      rdchk(ADDRS[r[1:0]]);
      idle();
      setchk();
      r = xs();
      smp(r[23:0], r[31:8]);
      stchk();
    end
    wr(8'h3c, 16'hffff, 4'hf);
    wr(8'h35, 16'h1234, 4'hf);
    rdchk(8'h3c);
    rdchk(8'h35);
    rdchk(8'h34);
    idle();
    do_reset();
    tally_and_finish();
  end
endmodule
